/* verilog/pcap_pkg.sv */
package pcap_pkg;
	// ************************************************************
	// Register map (byte addresses, channel stride 0x20)
	// ************************************************************
	localparam logic [7:0] PCAP_CH_STRIDE = 8'h20;
	localparam logic [4:0] PCAP_OFS_CTRL = 5'h00;
	localparam logic [4:0] PCAP_OFS_CFG = 5'h04;
	localparam logic [4:0] PCAP_OFS_STATUS = 5'h08;
	localparam logic [4:0] PCAP_OFS_VALUE = 5'h0c;

	// ************************************************************
	// Field positions in the configuration word
	// ************************************************************
	localparam int PCAP_CFG_SRC_LSB = 0;
	localparam int PCAP_CFG_MODE_LSB = 4;
	localparam int PCAP_CFG_EDGE_LSB = 6;
	localparam int PCAP_CFG_EVT_LSB = 8;
	localparam int PCAP_CFG_PEDGE_LSB = 10;
	localparam int PCAP_CFG_PSRC_LSB = 12;

	// ************************************************************
	// Reset values and encodings
	// ************************************************************
	localparam logic [3:0] PCAP_SRC_RESET = 4'h0;
	localparam logic [1:0] PCAP_EDGE_RESET = 2'h1;
	localparam logic [3:0] PCAP_SRC_DIFF0 = 4'h7;
	localparam logic [3:0] PCAP_SRC_INDEX = 4'ha;
	localparam logic [1:0] PCAP_EDGE_RISE = 2'h1;
	localparam logic [1:0] PCAP_EDGE_FALL = 2'h2;
	localparam logic [1:0] PCAP_EDGE_BOTH = 2'h3;

	typedef enum logic [1:0] {
		PCAP_MODE_POS = 2'b00,
		PCAP_MODE_TIME = 2'b01,
		PCAP_MODE_DC = 2'b10,
		PCAP_MODE_INDEX = 2'b11
	} pcap_mode_t;

	typedef enum logic [1:0] {
		PCAP_EVT_NONE = 2'b00,
		PCAP_EVT_AFTER = 2'b01,
		PCAP_EVT_HIGH = 2'b10,
		PCAP_EVT_LOW = 2'b11
	} pcap_evt_t;

	// ************************************************************
	// Timing: capture clock and nanosecond timestamp step
	// ************************************************************
	localparam int PCAP_CLK_MHZ = 40;
	localparam int PCAP_SAMPLE_KHZ = 16;
	localparam logic [31:0] PCAP_NS_PER_CLK = 32'(1000 / PCAP_CLK_MHZ);

	// Per-channel configuration
	typedef struct packed {
		logic [3:0] psrc;
		logic [1:0] pedge;
		pcap_evt_t evt;
		logic [1:0] edge_sel;
		pcap_mode_t mode;
		logic [3:0] src;
	} pcap_cfg_t;

	// Sampled quantities that may be latched
	typedef struct packed {
		logic [31:0] pos;
		logic [31:0] dc_time;
	} pcap_meas_t;
endpackage

/* verilog/pcap_top.sv */
// Implementation choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps

// ************************************************************
// One capture channel
// ************************************************************
module pcap_channel (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [10:0] sync_in,
	input wire logic [10:0] sync_prev,
	input wire pcap_pkg::pcap_cfg_t cfg,
	input wire logic arm_set,
	input wire logic arm_clr,
	input wire pcap_pkg::pcap_meas_t meas,
	input wire logic [31:0] ns_time,
	output logic armed,
	output logic done,
	output logic [31:0] value
);
	logic pre_seen;
	logic [31:0] next_value;

	// Source multiplexers share one code map for trigger and precondition
	wire trg_now = (cfg.src <= pcap_pkg::PCAP_SRC_INDEX) ?
		sync_in[cfg.src] : 1'b0;
	wire trg_old = (cfg.src <= pcap_pkg::PCAP_SRC_INDEX) ?
		sync_prev[cfg.src] : 1'b0;
	wire pre_now = (cfg.psrc <= pcap_pkg::PCAP_SRC_INDEX) ?
		sync_in[cfg.psrc] : 1'b0;
	wire pre_old = (cfg.psrc <= pcap_pkg::PCAP_SRC_INDEX) ?
		sync_prev[cfg.psrc] : 1'b0;
	// Mode 3 forces the encoder index regardless of the source setting
	wire idx_mode = (cfg.mode == pcap_pkg::PCAP_MODE_INDEX);
	wire t_now = idx_mode ? sync_in[pcap_pkg::PCAP_SRC_INDEX] : trg_now;
	wire t_old = idx_mode ? sync_prev[pcap_pkg::PCAP_SRC_INDEX] : trg_old;

	// Edge qualification, code 0 never fires
	wire t_rise = t_now & ~t_old;
	wire t_fall = ~t_now & t_old;
	wire t_edge = (cfg.edge_sel == pcap_pkg::PCAP_EDGE_RISE) ? t_rise :
		(cfg.edge_sel == pcap_pkg::PCAP_EDGE_FALL) ? t_fall :
		(cfg.edge_sel == pcap_pkg::PCAP_EDGE_BOTH) ? (t_rise | t_fall) :
		1'b0;
	wire p_rise = pre_now & ~pre_old;
	wire p_fall = ~pre_now & pre_old;
	wire p_edge = (cfg.pedge == pcap_pkg::PCAP_EDGE_RISE) ? p_rise :
		(cfg.pedge == pcap_pkg::PCAP_EDGE_FALL) ? p_fall :
		(cfg.pedge == pcap_pkg::PCAP_EDGE_BOTH) ? (p_rise | p_fall) :
		1'b0;

	// Precondition qualification; index mode ignores it
	wire qual = idx_mode ? 1'b1 :
		(cfg.evt == pcap_pkg::PCAP_EVT_NONE) ? 1'b1 :
		(cfg.evt == pcap_pkg::PCAP_EVT_AFTER) ? pre_seen :
		(cfg.evt == pcap_pkg::PCAP_EVT_HIGH) ? pre_now :
		~pre_now;
	wire fire = armed & t_edge & qual;

	// Quantity select; position may trail the event by feedback delay
	always_comb begin
		case (cfg.mode)
			pcap_pkg::PCAP_MODE_POS: next_value = meas.pos;
			pcap_pkg::PCAP_MODE_TIME: next_value = ns_time;
			pcap_pkg::PCAP_MODE_DC: next_value = meas.dc_time;
			pcap_pkg::PCAP_MODE_INDEX: next_value = meas.pos;
			default: next_value = meas.pos;
		endcase
	end

	// Arm state: an arm write beats a fire in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			armed <= 1'b0;
		end else if (arm_set) begin
			armed <= 1'b1;
		end else if (arm_clr || (fire && !idx_mode)) begin
			armed <= 1'b0;
		end
	end

	// Precondition memory cleared on each arming so stale edges don't count
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_seen <= 1'b0;
		end else if (arm_set || fire) begin
			pre_seen <= 1'b0;
		end else if (armed && p_edge) begin
			pre_seen <= 1'b1;
		end
	end

	// Latch in the detection cycle; done is sticky until rearm
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			value <= 32'h0;
			done <= 1'b0;
		end else if (fire) begin
			value <= next_value;
			done <= 1'b1;
		end else if (arm_set) begin
			done <= 1'b0;
		end
	end

	chk_disarm_a: assert property (@(posedge clk) disable iff (!rst_n)
		fire && !idx_mode && !arm_set |=> !armed)
		else $error("channel stayed armed after a single capture");
	chk_rearm_a: assert property (@(posedge clk) disable iff (!rst_n)
		fire && idx_mode && !arm_clr |=> armed)
		else $error("index mode did not rearm");
	chk_unarmed_a: assert property (@(posedge clk) disable iff (!rst_n)
		!armed |=> $stable(value))
		else $error("value changed on an unarmed channel");
	chk_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
		fire |=> value == $past(next_value) && done)
		else $error("latched value differs from selected quantity");
	chk_high_a: assert property (@(posedge clk) disable iff (!rst_n)
		fire && !idx_mode && cfg.evt == pcap_pkg::PCAP_EVT_HIGH
		|-> pre_now)
		else $error("fired while precondition low");
	chk_low_a: assert property (@(posedge clk) disable iff (!rst_n)
		fire && !idx_mode && cfg.evt == pcap_pkg::PCAP_EVT_LOW
		|-> !pre_now)
		else $error("fired while precondition high");
	chk_after_a: assert property (@(posedge clk) disable iff (!rst_n)
		fire && !idx_mode && cfg.evt == pcap_pkg::PCAP_EVT_AFTER
		|-> pre_seen)
		else $error("fired without earlier precondition edge");
	chk_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
		fire && cfg.edge_sel == pcap_pkg::PCAP_EDGE_RISE
		|-> t_now && !t_old)
		else $error("rising capture without rising edge");
	cov_pos_c: cover property (@(posedge clk) disable iff (!rst_n)
		fire && cfg.mode == pcap_pkg::PCAP_MODE_POS);
	cov_index_c: cover property (@(posedge clk) disable iff (!rst_n)
		fire && idx_mode ##[1:200] fire);
	cov_after_c: cover property (@(posedge clk) disable iff (!rst_n)
		fire && cfg.evt == pcap_pkg::PCAP_EVT_AFTER);
endmodule

// ************************************************************
// Top: synchronisers, time base and AHB-Lite slave
// ************************************************************
module pcap_top (
	// Clock and reset
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	// Trigger pins: digital 1-7, differential 1-3, encoder index
	input wire logic [6:0] DIG_IN,
	input wire logic [2:0] DIFF_IN,
	input wire logic INDEX_IN,
	// Quantities from same-clock logic
	input wire logic [31:0] POSITION_IN,
	input wire logic [31:0] DC_TIME_IN,
	// AHB-Lite slave
	input wire logic HSEL_IN,
	input wire logic [31:0] HADDR_IN,
	input wire logic [1:0] HTRANS_IN,
	input wire logic HWRITE_IN,
	input wire logic [2:0] HSIZE_IN,
	input wire logic [31:0] HWDATA_IN,
	input wire logic HREADY_IN,
	output logic [31:0] HRDATA_OUT,
	output logic HREADYOUT_OUT,
	output logic HRESP_OUT
);
	logic [10:0] sync1;
	logic [10:0] sync2;
	logic [10:0] sync3;
	logic [31:0] ns_time;
	logic wr_pend;
	logic [7:0] wr_addr;
	logic [31:0] next_rdata;
	pcap_pkg::pcap_cfg_t cfg [2];
	logic [1:0] armed;
	logic [1:0] done;
	logic [31:0] value [2];
	pcap_pkg::pcap_meas_t meas;

	assign meas = '{pos: POSITION_IN, dc_time: DC_TIME_IN};

	// Two-stage synchroniser, third stage keeps the previous level
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			sync1 <= 11'h0;
			sync2 <= 11'h0;
			sync3 <= 11'h0;
		end else begin
			sync1 <= {INDEX_IN, DIFF_IN, DIG_IN};
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// Free-running nanosecond time base
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			ns_time <= 32'h0;
		end else begin
			ns_time <= ns_time + pcap_pkg::PCAP_NS_PER_CLK;
		end
	end

	// Address phase decode; writes complete in the data phase
	wire addr_ok = HSEL_IN && HREADY_IN && HTRANS_IN[1];
	wire [7:0] rd_addr = HADDR_IN[7:0];
	wire rd_ch = rd_addr[5];

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h0;
		end else begin
			wr_pend <= addr_ok && HWRITE_IN;
			wr_addr <= HADDR_IN[7:0];
		end
	end

	// Read mux; unmapped offsets read zero
	always_comb begin
		next_rdata = 32'h0;
		if (addr_ok && !HWRITE_IN && rd_addr[7:6] == 2'b00) begin
			case (rd_addr[4:0])
				pcap_pkg::PCAP_OFS_CFG: next_rdata = {16'h0, cfg[rd_ch]};
				pcap_pkg::PCAP_OFS_STATUS:
					next_rdata = {30'h0, done[rd_ch], armed[rd_ch]};
				pcap_pkg::PCAP_OFS_VALUE: next_rdata = value[rd_ch];
				default: next_rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			HRDATA_OUT <= 32'h0;
			HREADYOUT_OUT <= 1'b1;
			HRESP_OUT <= 1'b0;
		end else begin
			HRDATA_OUT <= next_rdata;
			HREADYOUT_OUT <= 1'b1;
			HRESP_OUT <= 1'b0;
		end
	end

	// One channel per generate step, each with its own registers
	for (genvar ch = 0; ch < 2; ch++) begin : g_ch
		wire sel = wr_pend && wr_addr[7:6] == 2'b00 && wr_addr[5] == ch;
		wire ctrl_wr = sel && wr_addr[4:0] == pcap_pkg::PCAP_OFS_CTRL;
		wire cfg_wr = sel && wr_addr[4:0] == pcap_pkg::PCAP_OFS_CFG;

		// Configuration writes act at once, even while the channel is armed
		always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
			if (!RST_N_IN) begin
				cfg[ch] <= '{psrc: pcap_pkg::PCAP_SRC_RESET,
					pedge: pcap_pkg::PCAP_EDGE_RESET,
					evt: pcap_pkg::PCAP_EVT_NONE,
					edge_sel: pcap_pkg::PCAP_EDGE_RESET,
					mode: pcap_pkg::PCAP_MODE_POS,
					src: pcap_pkg::PCAP_SRC_RESET};
			end else if (cfg_wr) begin
				cfg[ch] <= pcap_pkg::pcap_cfg_t'(HWDATA_IN[15:0]);
			end
		end

		pcap_channel u_ch (
			.clk(CLK_IN),
			.rst_n(RST_N_IN),
			.sync_in(sync2),
			.sync_prev(sync3),
			.cfg(cfg[ch]),
			.arm_set(ctrl_wr && HWDATA_IN[0]),
			.arm_clr(ctrl_wr && !HWDATA_IN[0]),
			.meas(meas),
			.ns_time(ns_time),
			.armed(armed[ch]),
			.done(done[ch]),
			.value(value[ch])
		);
	end
endmodule

/* sim/pcap_far.sv */
`timescale 1ns/1ps
// Far side: trigger pins and a moving axis
module pcap_far (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Pin levels and axis speed from the bench
	input wire logic [10:0] pins_in,
	input wire logic [15:0] step_in,
	// Pins and measured quantities
	output logic [6:0] dig_out,
	output logic [2:0] diff_out,
	output logic index_out,
	output logic [31:0] pos_out,
	output logic [31:0] dc_out
);
	// Bit n of pins_in is the pin behind source code n
	assign dig_out = pins_in[6:0];
	assign diff_out = pins_in[9:7];
	assign index_out = pins_in[10];
	// The axis never stands still, so a late latch shows up
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pos_out <= 32'h0;
			dc_out <= 32'h0;
		end else begin
			pos_out <= pos_out + {16'h0, step_in};
			dc_out <= dc_out + 32'h3;
		end
	end
endmodule

/* sim/pcap_top_tb.sv */
`timescale 1ns/1ps
module pcap_top_tb;
	// Reset is released at this edge; the time base counts from there
	localparam int rst_cycles = 6;
	logic clk = 0;
	logic rst_n = 0;
	logic [10:0] pins = 0;
	logic [15:0] step = 16'h10;
	logic [15:0] lfsr = 16'h10;
	logic hsel = 0;
	logic [31:0] haddr = 0;
	logic [1:0] htrans = 0;
	logic hwrite = 0;
	logic [31:0] hwdata = 0;
	logic [31:0] hrdata;
	logic hready;
	logic hresp;
	logic [6:0] dig;
	logic [2:0] diff;
	logic idx;
	logic [31:0] pos;
	logic [31:0] dc;
	logic [31:0] rd;
	logic [31:0] tprev;
	logic [31:0] vm[2] = '{0, 0};
	bit dn[2] = '{0, 0};
	bit ar[2] = '{0, 0};
	int fails = 0;
	int n_checks = 0;
	int cyc = 0;
	int cprev = -1;

	// ********************
	// Design and far side
	// ********************
	pcap_top pcap_top_inst (.CLK_IN(clk), .RST_N_IN(rst_n),
		.DIG_IN(dig), .DIFF_IN(diff), .INDEX_IN(idx),
		.POSITION_IN(pos), .DC_TIME_IN(dc), .HSEL_IN(hsel),
		.HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
		.HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hready),
		.HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp));
	pcap_far pcap_far_inst (.clk_in(clk), .rst_n_in(rst_n),
		.pins_in(pins), .step_in(step), .dig_out(dig),
		.diff_out(diff), .index_out(idx), .pos_out(pos), .dc_out(dc));

	// Clock, and a cycle ceiling in case the bus hangs
	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			end_of_test;
		end
	end

	function automatic logic [15:0] nx(logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One single word transfer; waits on hready at both phases
	task automatic bus(input logic wr, input logic [31:0] a,
		input logic [31:0] d);
		@(posedge clk);
		hsel <= 1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
		chk({31'h0, hresp}, 0);
		hsel <= 0;
	endtask

	// Configure, arm, make the edges, then compare with the model
	task automatic trial(int ch, bit arm, int s, int m, int e, int v,
		int pe, int ps, bit c0, bit p0, bit pt, bit fire);
		int cp;
		int ccur;
		logic [31:0] b;
		logic [31:0] expv;
		pcap_pkg::pcap_cfg_t c;
		b = 32'(ch) * 32'h20;
		c = {4'(ps), 2'(pe), 2'(v), 2'(e), 2'(m), 4'(s)};
		cp = m == 3 ? 10 : s;
		if (arm) begin
			bus(1, 0, 0);
			bus(1, 32'h20, 0);
			ar[0] = 0;
			ar[1] = 0;
		end
		@(posedge clk);
		pins <= (11'(c0) << cp) | (11'(p0) << ps);
		repeat (4) @(posedge clk);
		bus(1, b + 4, {16'h0, c});
		bus(0, b + 4, 0);
		chk(rd, {16'h0, c});
		if (arm) begin
			bus(1, b, 1);
			dn[ch] = 0;
			ar[ch] = 1;
		end
		if (pt) begin
			pins[ps] <= !p0;
			repeat (4) @(posedge clk);
		end
		pins[cp] <= !c0;
		repeat (2) @(posedge clk);
		#1;
		expv = m == 2 ? dc : m == 1 ? 32'(cyc - rst_cycles) * 32'd25 : pos;
		ccur = cyc;
		repeat (4) @(posedge clk);
		if (fire) begin
			dn[ch] = 1;
			ar[ch] = m == 3;
			vm[ch] = expv;
		end
		bus(0, b + 8, 0);
		chk(rd, {30'h0, dn[ch], ar[ch]});
		bus(0, b + 12, 0);
		if (fire && m == 1) begin
			if (cprev >= 0)
				chk(rd - tprev, 32'(ccur - cprev) * 32'd25);
			tprev = rd;
			cprev = ccur;
		end
		chk(rd, vm[ch]);
	endtask

	// Main sequence
	initial begin
		repeat (rst_cycles) @(posedge clk);
		rst_n <= 1;
		bus(0, 32'h4, 0);
		chk(rd, 32'h440);
		bus(0, 32'h24, 0);
		chk(rd, 32'h440);
		bus(0, 32'h40, 0);
		chk(rd, 0);
		for (int s = 0; s < 11; s++) begin
			lfsr = nx(lfsr);
			step <= lfsr;
			trial(s % 2, 1, s, 0, 1, 0, 1, (s + 1) % 11, 0, 0, 0, 1);
		end
		trial(0, 1, 3, 0, 2, 0, 1, 4, 0, 0, 0, 0);
		trial(0, 1, 3, 0, 2, 0, 1, 4, 1, 0, 0, 1);
		trial(1, 1, 3, 0, 3, 0, 1, 4, 1, 0, 0, 1);
		trial(1, 1, 3, 0, 3, 0, 1, 4, 0, 0, 0, 1);
		trial(1, 1, 3, 0, 0, 0, 1, 4, 0, 0, 0, 0);
		trial(0, 0, 3, 0, 1, 0, 1, 4, 0, 0, 0, 0);
		trial(1, 1, 5, 0, 1, 1, 1, 2, 0, 0, 0, 0);
		trial(1, 1, 5, 0, 1, 1, 1, 2, 0, 0, 1, 1);
		trial(0, 1, 5, 0, 1, 1, 2, 8, 0, 1, 1, 1);
		trial(0, 1, 5, 0, 1, 1, 3, 8, 0, 0, 1, 1);
		trial(1, 1, 6, 0, 1, 2, 1, 9, 0, 1, 0, 1);
		trial(1, 1, 6, 0, 1, 2, 1, 9, 0, 0, 0, 0);
		trial(0, 1, 6, 0, 1, 3, 1, 9, 0, 0, 0, 1);
		trial(0, 1, 6, 0, 1, 3, 1, 9, 0, 1, 0, 0);
		trial(0, 1, 2, 2, 1, 0, 1, 3, 0, 0, 0, 1);
		trial(1, 1, 2, 1, 1, 0, 1, 3, 0, 0, 0, 1);
		trial(1, 1, 2, 1, 2, 0, 1, 3, 1, 0, 0, 1);
		trial(0, 1, 4, 3, 3, 0, 1, 3, 0, 0, 0, 1);
		trial(0, 0, 4, 3, 3, 0, 1, 3, 1, 0, 0, 1);
		bus(1, 0, 0);
		end_of_test;
	end
endmodule
